// file: rtl/bra_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module bra_arbiter (
  // Clock and reset
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_i,
  // Buffer clock and peripheral request pins
  input  wire logic                         buffer_clock_n_i,
  input  wire logic                         peripheral_transfer_request_n_i,
  // Internal SCSI core request
  input  wire logic                         scsi_transfer_request_i,
  // Buffer address pointers and direction
  input  wire logic [bra_pkg::BRA_PTR_W-1:0] read_address_pointer_i,
  input  wire logic [bra_pkg::BRA_PTR_W-1:0] write_address_pointer_i,
  input  wire logic                         peri_read_i,
  // Grants and peripheral buffer address
  output logic                              peri_grant_o,
  output logic                              scsi_grant_o,
  output logic [bra_pkg::BRA_PTR_W-1:0]     peri_addr_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic                         clk_n_s;
  logic                         req_n_s;
  logic                         fall;
  logic                         rise;
  logic                         end_edge;
  logic [bra_pkg::BRA_PTR_W-1:0] ptr_sel;
  bra_pkg::bra_state_t          st;
  bra_pkg::bra_state_t          next_st;

  bra_sync #(
    .RST_VAL (bra_pkg::BRA_CLK_N_IDLE)
  ) u_clk_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .d_i        (buffer_clock_n_i),
    .q_o        (clk_n_s)
  );

  bra_sync #(
    .RST_VAL (bra_pkg::BRA_REQ_N_IDLE)
  ) u_req_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .d_i        (peripheral_transfer_request_n_i),
    .q_o        (req_n_s)
  );

  // ----------------------------------------------------------------
  // Buffer clock edges
  // ----------------------------------------------------------------
  assign fall     = st.clk_prev & ~clk_n_s;
  assign rise     = ~st.clk_prev & clk_n_s;
  // A grant lasts one buffer period, closed by the same kind of edge
  assign end_edge = st.on_fall ? fall : rise;
  // Pointer chosen by the transfer direction
  assign ptr_sel  = peri_read_i ? read_address_pointer_i : write_address_pointer_i;

  // ----------------------------------------------------------------
  // Capture and arbitration
  // ----------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.clk_prev = clk_n_s;
    // Captures set pending; a later clear in this process only comes with a grant
    if (fall && !req_n_s) begin
      next_st.ext_pend = 1'b1;
    end
    if (rise && scsi_transfer_request_i) begin
      next_st.scsi_pend = 1'b1;
    end
    unique case (st.phase)
      bra_pkg::BRA_IDLE: begin
        // Only one edge per core cycle, so the first capture wins
        if (fall && next_st.ext_pend) begin
          next_st.phase      = bra_pkg::BRA_PERI;
          next_st.grant_peri = 1'b1;
          next_st.on_fall    = 1'b1;
          next_st.ext_pend   = 1'b0;
          next_st.addr       = ptr_sel;
        end else if (rise && next_st.scsi_pend) begin
          next_st.phase      = bra_pkg::BRA_SCSI;
          next_st.grant_scsi = 1'b1;
          next_st.on_fall    = 1'b0;
          next_st.scsi_pend  = 1'b0;
        end
      end
      bra_pkg::BRA_PERI: begin
        if (end_edge) begin
          next_st.grant_peri = 1'b0;
          if (next_st.scsi_pend) begin
            // One idle period, then SCSI on the second edge
            next_st.phase = bra_pkg::BRA_TO_SCSI;
          end else if (next_st.ext_pend) begin
            next_st.grant_peri = 1'b1;
            next_st.ext_pend   = 1'b0;
            next_st.addr       = ptr_sel;
          end else begin
            next_st.phase = bra_pkg::BRA_IDLE;
          end
        end
      end
      bra_pkg::BRA_TO_SCSI: begin
        if (end_edge) begin
          next_st.phase      = bra_pkg::BRA_SCSI;
          next_st.grant_scsi = 1'b1;
          next_st.scsi_pend  = 1'b0;
        end
      end
      bra_pkg::BRA_SCSI: begin
        // The running SCSI cycle is never cut short
        if (end_edge) begin
          next_st.grant_scsi = 1'b0;
          if (next_st.ext_pend) begin
            next_st.phase      = bra_pkg::BRA_PERI;
            next_st.grant_peri = 1'b1;
            next_st.ext_pend   = 1'b0;
            next_st.addr       = ptr_sel;
          end else if (next_st.scsi_pend) begin
            next_st.grant_scsi = 1'b1;
            next_st.scsi_pend  = 1'b0;
          end else begin
            next_st.phase = bra_pkg::BRA_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= bra_pkg::BRA_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign peri_grant_o = st.grant_peri;
  assign scsi_grant_o = st.grant_scsi;
  assign peri_addr_o  = st.addr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_peri_start;
    !st.grant_peri ##1 st.grant_peri;
  endsequence

  sequence s_scsi_end_ext;
    st.phase == bra_pkg::BRA_SCSI && end_edge && next_st.ext_pend;
  endsequence

  a_grant_mutex: assert property (!(st.grant_peri && st.grant_scsi))
    else $error("both requesters granted");

  a_ext_capture: assert property (
    fall && !req_n_s |=> st.ext_pend || st.grant_peri)
    else $error("peripheral request lost at falling edge");

  a_ext_edge_only: assert property (
    !st.ext_pend ##1 st.ext_pend |-> $past(fall))
    else $error("peripheral request captured off the falling edge");

  a_scsi_edge_only: assert property (
    !st.scsi_pend ##1 st.scsi_pend |-> $past(rise))
    else $error("scsi request captured off the rising edge");

  a_first_wins: assert property (
    st.phase == bra_pkg::BRA_IDLE && fall && !req_n_s
    |=> st.grant_peri && !st.grant_scsi)
    else $error("earlier peripheral request not granted");

  a_scsi_two_later: assert property (
    st.phase == bra_pkg::BRA_PERI && end_edge && next_st.scsi_pend
    |=> !st.grant_scsi && st.phase == bra_pkg::BRA_TO_SCSI)
    else $error("scsi not deferred after peripheral grant");

  a_scsi_on_edge: assert property (
    st.phase == bra_pkg::BRA_TO_SCSI && end_edge |=> st.grant_scsi)
    else $error("scsi not granted on second period edge");

  a_peri_one_later: assert property (s_scsi_end_ext |=> st.grant_peri)
    else $error("peripheral not granted one period after scsi");

  a_scsi_complete: assert property (
    st.grant_scsi && !end_edge |=> st.grant_scsi)
    else $error("scsi transfer cut short");

  a_addr_select: assert property (
    s_peri_start |-> st.addr == $past(ptr_sel))
    else $error("peripheral address not from current pointer");

  a_pend_held: assert property (
    st.ext_pend |=> st.ext_pend || st.grant_peri)
    else $error("peripheral request dropped without service");

  a_scsi_capture: assert property (
    rise && scsi_transfer_request_i |=> st.scsi_pend || st.grant_scsi)
    else $error("scsi request lost at rising edge");

  a_scsi_pend_held: assert property (
    st.scsi_pend |=> st.scsi_pend || st.grant_scsi)
    else $error("scsi request dropped without service");

  a_idle_no_grant: assert property (
    st.phase == bra_pkg::BRA_IDLE |-> !st.grant_peri && !st.grant_scsi)
    else $error("grant held while arbiter idle");

  // The deferral period leaves the buffer unused on purpose
  a_gap_no_grant: assert property (
    st.phase == bra_pkg::BRA_TO_SCSI |-> !st.grant_peri && !st.grant_scsi)
    else $error("buffer granted during the deferral period");

  a_peri_addr_hold: assert property (
    st.grant_peri && !end_edge |=> st.grant_peri && $stable(st.addr))
    else $error("peripheral grant or address changed mid-cycle");

endmodule
`default_nettype wire

// file: rtl/bra_pkg.sv
`default_nettype none
package bra_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int unsigned BRA_PTR_W           = 16;
  localparam int unsigned BRA_CORE_PERIOD_NS  = 8;
  localparam int unsigned BRA_BUF_CLK_MIN_NS  = 200;
  // Shortest buffer clock period in core cycles, rounded up
  localparam int unsigned BRA_BUF_CLK_MIN_CYC =
    (BRA_BUF_CLK_MIN_NS + BRA_CORE_PERIOD_NS - 1) / BRA_CORE_PERIOD_NS;

  // ----------------------------------------------------------------
  // Pin idle levels
  // ----------------------------------------------------------------
  localparam logic BRA_REQ_N_IDLE = 1'b1;
  localparam logic BRA_CLK_N_IDLE = 1'b1;

  // ----------------------------------------------------------------
  // Arbiter state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BRA_IDLE,
    BRA_PERI,
    BRA_TO_SCSI,
    BRA_SCSI
  } bra_phase_t;

  typedef struct packed {
    bra_phase_t             phase;
    logic                   ext_pend;
    logic                   scsi_pend;
    logic                   on_fall;
    logic                   clk_prev;
    logic                   grant_peri;
    logic                   grant_scsi;
    logic [BRA_PTR_W-1:0]   addr;
  } bra_state_t;

  localparam bra_state_t BRA_STATE_RST = '{
    phase:    BRA_IDLE,
    clk_prev: BRA_CLK_N_IDLE,
    default:  '0
  };

  // ----------------------------------------------------------------
  // Synchroniser state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic q;
  } bra_sync_t;

endpackage
`default_nettype wire

// file: rtl/bra_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bra_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // Pin and filtered level
  input  wire logic d_i,
  output logic      q_o
);

  bra_pkg::bra_sync_t st;
  bra_pkg::bra_sync_t next_st;

  // A level is taken only once the second and third stage agree
  always_comb begin
    next_st     = st;
    next_st.ff1 = d_i;
    next_st.ff2 = st.ff1;
    next_st.ff3 = st.ff2;
    if (st.ff2 == st.ff3) begin
      next_st.q = st.ff3;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '{ff1: RST_VAL, ff2: RST_VAL, ff3: RST_VAL, q: RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.q;

endmodule
`default_nettype wire

// file: testbench/bra_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Far side: buffer clock, peripheral and SCSI requesters
// ----------------------------------------------------------------
module bra_partner #(
  parameter int HALF = 13
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // Bench commands
  input  wire logic peri_cmd_i,
  input  wire logic scsi_cmd_i,
  // Driven pins and request
  output logic      buf_clk_n_o,
  output logic      peri_req_n_o,
  output logic      scsi_req_o
);
  int cnt;

  // Requests move half a period away from their sampling edge for setup and hold
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt = 0;
      buf_clk_n_o <= 1'b1;
      peri_req_n_o <= 1'b1;
      scsi_req_o <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt = 0;
      buf_clk_n_o <= #1 ~buf_clk_n_o;
      if (buf_clk_n_o === 1'b0) begin
        peri_req_n_o <= #1 ~peri_cmd_i;
      end else begin
        scsi_req_o <= #1 scsi_cmd_i;
      end
    end else begin
      cnt = cnt + 1;
    end
  end
endmodule
`default_nettype wire

// file: testbench/buffer_request_arbiter_test.sv
`timescale 1ns/1ps
`default_nettype none
module buffer_request_arbiter_test;
  logic        core_clk_i = 1'b0;
  logic        rst_i      = 1'b1;
  logic        peri_cmd   = 1'b0;
  logic        scsi_cmd   = 1'b0;
  logic        peri_read  = 1'b0;
  logic [15:0] rd_ptr     = 16'h0000;
  logic [15:0] wr_ptr     = 16'h0000;
  logic        bprev      = 1'b1;
  logic        gp         = 1'b0;
  logic        gs         = 1'b0;
  wire logic   bclk_n;
  wire logic   req_n;
  wire logic   scsi_req;
  wire logic   peri_grant;
  wire logic   scsi_grant;
  wire logic [15:0] peri_addr;
  int          mismatches = 0;
  int          checks_done = 0;
  int          seed = 32'h6b65;
  int          edges = 0;
  int          s_edge = 0;
  int          q_kind[$];
  int          q_edge[$];
  logic [15:0] q_addr[$];

  always #4 core_clk_i = ~core_clk_i;

  bra_partner i_bra_partner (.core_clk_i(core_clk_i), .rst_i(rst_i), .peri_cmd_i(peri_cmd),
    .scsi_cmd_i(scsi_cmd), .buf_clk_n_o(bclk_n), .peri_req_n_o(req_n), .scsi_req_o(scsi_req));

  bra_arbiter i_bra_arbiter (.core_clk_i(core_clk_i), .rst_i(rst_i), .buffer_clock_n_i(bclk_n),
    .peripheral_transfer_request_n_i(req_n), .scsi_transfer_request_i(scsi_req),
    .read_address_pointer_i(rd_ptr), .write_address_pointer_i(wr_ptr), .peri_read_i(peri_read),
    .peri_grant_o(peri_grant), .scsi_grant_o(scsi_grant), .peri_addr_o(peri_addr));

  task automatic report_and_stop();
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmp_seq(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_addr(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t addr got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Grant starts are logged with the buffer clock edge count at that moment
  // This monitor looks at nothing while reset is applied: outputs are unknown before the first edge
  always @(posedge core_clk_i) begin
    if (!rst_i) begin
      if (bclk_n !== bprev) edges++;
      bprev = bclk_n;
      cmp_seq({31'h0, peri_grant & scsi_grant}, 32'h0);
      if (peri_grant === 1'b1 && gp === 1'b0) begin
        q_kind.push_back(1);
        q_edge.push_back(edges);
        q_addr.push_back(peri_addr);
      end
      if (scsi_grant === 1'b1 && gs === 1'b0) begin
        q_kind.push_back(2);
        q_edge.push_back(edges);
        q_addr.push_back(peri_addr);
        s_edge = edges;
      end
      if (scsi_grant === 1'b0 && gs === 1'b1) begin
        cmp_seq(edges - s_edge, 2);
      end
      gp = peri_grant;
      gs = scsi_grant;
    end
  end

  task automatic wait_pin(input logic lvl);
    int n;
    n = 0;
    @(posedge core_clk_i);
    while (bclk_n !== lvl && n < 40) begin
      @(posedge core_clk_i);
      n++;
    end
    if (n >= 40) begin
      mismatches++;
      report_and_stop();
    end
    #1;
  endtask

  // ----------------------------------------------------------------
  // Modes: 0 peri, 1 peri then SCSI, 2 SCSI then peri, 3 SCSI
  // ----------------------------------------------------------------
  task automatic run(input logic [1:0] mode);
    logic [15:0] ea;
    int k0;
    int n;
    q_kind.delete();
    q_edge.delete();
    q_addr.delete();
    wait_pin(~mode[1]);
    rd_ptr = 16'($random(seed));
    wr_ptr = 16'($random(seed));
    peri_read = 1'($random(seed));
    ea = peri_read ? rd_ptr : wr_ptr;
    wait_pin(mode[1]);
    peri_cmd = (mode != 2'h3);
    scsi_cmd = (mode != 2'h0);
    wait_pin(~mode[1]);
    wait_pin(mode[1]);
    peri_cmd = 1'b0;
    scsi_cmd = 1'b0;
    repeat (150) @(posedge core_clk_i);
    n = (mode == 2'h0 || mode == 2'h3) ? 1 : 2;
    k0 = (mode < 2'h2) ? 1 : 2;
    cmp_seq(q_kind.size(), n);
    if (q_kind.size() == n) begin
      cmp_seq(q_kind[0], k0);
      if (k0 == 1) cmp_addr(q_addr[0], ea);
      if (n == 2) begin
        cmp_seq(q_kind[1], 3 - k0);
        cmp_seq(q_edge[1] - q_edge[0], (k0 == 1) ? 4 : 2);
        if (k0 == 2) cmp_addr(q_addr[1], ea);
      end
    end
  endtask

  // A reset in the middle of a grant must drop it at once; a normal run follows
  task automatic reset_mid_run();
    int n;
    n = 0;
    #1;
    peri_cmd = 1'b1;
    while (peri_grant !== 1'b1 && n < 80) begin
      @(posedge core_clk_i);
      n++;
    end
    if (n >= 80) begin
      mismatches++;
      report_and_stop();
    end
    #1;
    rst_i = 1'b1;
    peri_cmd = 1'b0;
    #2;
    cmp_seq({30'h0, peri_grant, scsi_grant}, 32'h0);
    repeat (2) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    run(2'h1);
  endtask

  initial begin
    repeat (6) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    for (int i = 0; i < 16; i++) run(i[1:0]);
    reset_mid_run();
    report_and_stop();
  end
endmodule
`default_nettype wire
